// ==== src/gp_int_pkg.sv ====
// Package for the interrupt aggregator: word widths, bit positions, register map.
// Assumes a single clock domain and an Avalon-MM slave with 32-bit data.
`default_nettype none
package gp_int_pkg;
  localparam int STAT_W = 48;
  localparam int AW     = 5;
  // Upper-word bit positions
  localparam int B_SPI1_ABORT   = 36;
  localparam int B_CLKRD_ABORT  = 35;
  localparam int B_SRC_RED1     = 34;
  localparam int B_SRC_RED0     = 33;
  localparam int B_RF0_UNLOCK   = 32;
  localparam int B_RF1_UNLOCK   = 31;
  localparam int B_CLK_UNLOCK   = 30;
  localparam int B_RF0_CP_OVR   = 29;
  localparam int B_RF1_CP_OVR   = 28;
  localparam int B_CLK_OVR      = 27;
  localparam int B_SER_UNLOCK   = 26;
  localparam int B_TX_PWR_BASE  = 10;
  localparam int B_TX_SLEW_BASE = 11;
  localparam int B_CORE0_BASE   = 5;
  localparam int B_CORE1_BASE   = 0;
  localparam int N_TX           = 8;
  localparam int N_CORE_EV      = 5;
  // Register word indices (byte address = 4 * index)
  localparam logic [AW-1:0] R_STAT_LO   = 5'h00;
  localparam logic [AW-1:0] R_STAT_HI   = 5'h01;
  localparam logic [AW-1:0] R_STICKY_LO = 5'h02;
  localparam logic [AW-1:0] R_STICKY_HI = 5'h03;
  localparam logic [AW-1:0] R_MASKA_LO  = 5'h04;
  localparam logic [AW-1:0] R_MASKA_HI  = 5'h05;
  localparam logic [AW-1:0] R_MASKB_LO  = 5'h06;
  localparam logic [AW-1:0] R_MASKB_HI  = 5'h07;
  localparam logic [AW-1:0] R_MASKAB_LO = 5'h08;
  localparam logic [AW-1:0] R_MASKAB_HI = 5'h09;
  localparam logic [AW-1:0] R_RAW_LO    = 5'h0A;
  localparam logic [AW-1:0] R_RAW_HI    = 5'h0B;
  // Reset values
  localparam logic [STAT_W-1:0] MASK_RST   = 48'hFFFF_FFFF_FFFF;
  localparam logic [STAT_W-1:0] STICKY_RST = 48'h0000_0000_0000;
  localparam logic [31:0]       BAD_ADDR_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] sticky;
    logic [STAT_W-1:0] mask_a;
    logic [STAT_W-1:0] mask_b;
    logic [31:0]       rdata;
    logic              rvalid;
  } agg_state_s;

  typedef struct packed {
    logic [STAT_W-1:0] lo;
    logic [STAT_W-1:0] hi;
  } word_pair_s;

  // Update the low 32 bits or the high 16 bits of a 48-bit word
  function automatic logic [STAT_W-1:0] put_half(input logic [STAT_W-1:0] old, input logic hi,
                                                 input logic [31:0] d);
    logic [STAT_W-1:0] r;
    r = old;
    if (hi)
    begin
      r[STAT_W-1:32] = d[STAT_W-33:0];
    end
    else
    begin
      r[31:0] = d;
    end
    return r;
  endfunction

  function automatic logic [31:0] get_half(input logic [STAT_W-1:0] v, input logic hi);
    logic [31:0] r;
    r = hi ? {16'h0000, v[STAT_W-1:32]} : v[31:0];
    return r;
  endfunction
endpackage
`default_nettype wire

// ==== src/gp_int_pin.sv ====
// One interrupt pin: OR of the upper-word status bits unmasked in its own mask.
// Assumes status and mask are registered by the caller.
`default_nettype none
module gp_int_pin
  import gp_int_pkg::*;
(
  input  wire logic [STAT_W-1:0] status_in,
  input  wire logic [STAT_W-1:0] mask_in,
  output logic                   irq_out
);
  assign irq_out = |(status_in & ~mask_in);
endmodule // gp_int_pin
`default_nettype wire

// ==== src/gp_interrupt_aggregator.sv ====
// Upper-word interrupt aggregator: status capture, sticky select, two masked pins.
// Assumes sources synchronous to CLK_IN; Avalon-MM slave answers after one wait cycle.
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`default_nettype none
// Behaviour
// - Loop unlock and overrange events land on upper-word bits 32 down to 26.
// - Transmit channel n sets bit 11+2n on slew, 10+2n on power protection.
// - Core 0 forced, watchdog, calibration, system, ECC events on bits 9..5.
// - Core 1 forced, watchdog, calibration, system, ECC events on bits 4..0.
// - Serial port aborts at bits 36, 35; source reducer errors at 34, 33.
// - Per-source type register picks sticky capture or level following.
// - Sticky status bit stays set after source drops until host clears it.
// - Clear touches only bits selected in the clear select word.
// - Full status is readable by the host.
// - Two independent masks, writable alone or together, readable alone; the joint address reads mask A.
// - Each pin stays high while any unmasked status bit is set.
// - With no unmasked status bit set, both pins are low.
// - Mask bit zero passes the source, mask bit one blocks it.
// - Each pin is the OR of sources unmasked in its own mask.
// - Each mask is a 48-bit word with unused positions reserved.
module gp_interrupt_aggregator
  import gp_int_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic              CLK_EN_IN,
  input  wire logic [3:0]        SPI_ABORT_IN,
  input  wire logic [6:0]        PLL_EVENT_IN,
  input  wire logic [N_TX-1:0]   TX_SLEW_IN,
  input  wire logic [N_TX-1:0]   TX_POWER_IN,
  input  wire logic [4:0]        CORE0_EVENT_IN,
  input  wire logic [4:0]        CORE1_EVENT_IN,
  input  wire logic [AW-1:0]     AVS_ADDRESS_IN,
  input  wire logic              AVS_READ_IN,
  input  wire logic              AVS_WRITE_IN,
  input  wire logic [31:0]       AVS_WRITEDATA_IN,
  input  wire logic [3:0]        AVS_BYTEENABLE_IN,
  output logic [31:0]            AVS_READDATA_OUT,
  output logic                   AVS_WAITREQUEST_OUT,
  output logic [1:0]             AVS_RESPONSE_OUT,
  output logic                   IRQ_PIN_A_OUT,
  output logic                   IRQ_PIN_B_OUT,
  output logic                   IRQ_OUT
);
  agg_state_s        st_reg;
  agg_state_s        st_next;
  logic [STAT_W-1:0] raw;
  logic [STAT_W-1:0] clear_select_word;
  logic [STAT_W-1:0] event_now;
  logic              acc;
  logic              hi_sel;
  logic              mapped;
  logic              pin_a;
  logic              pin_b;
  logic [31:0]       wmask;

  // Source map onto the upper word
  always_comb
  begin
    raw = '0;
    raw[B_SPI1_ABORT]  = SPI_ABORT_IN[3];
    raw[B_CLKRD_ABORT] = SPI_ABORT_IN[2];
    raw[B_SRC_RED1]    = SPI_ABORT_IN[1];
    raw[B_SRC_RED0]    = SPI_ABORT_IN[0];
    raw[B_RF0_UNLOCK]  = PLL_EVENT_IN[6];
    raw[B_RF1_UNLOCK]  = PLL_EVENT_IN[5];
    raw[B_CLK_UNLOCK]  = PLL_EVENT_IN[4];
    raw[B_RF0_CP_OVR]  = PLL_EVENT_IN[3];
    raw[B_RF1_CP_OVR]  = PLL_EVENT_IN[2];
    raw[B_CLK_OVR]     = PLL_EVENT_IN[1];
    raw[B_SER_UNLOCK]  = PLL_EVENT_IN[0];
    for (int n = 0; n < N_TX; n++)
    begin
      raw[B_TX_SLEW_BASE + 2*n] = TX_SLEW_IN[n];
      raw[B_TX_PWR_BASE + 2*n]  = TX_POWER_IN[n];
    end
    raw[B_CORE0_BASE +: N_CORE_EV] = CORE0_EVENT_IN;
    raw[B_CORE1_BASE +: N_CORE_EV] = CORE1_EVENT_IN;
  end

  assign acc       = AVS_READ_IN | AVS_WRITE_IN;
  assign hi_sel    = AVS_ADDRESS_IN[0];
  assign mapped    = AVS_ADDRESS_IN <= R_RAW_HI;
  assign wmask     = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                      {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  assign event_now = raw;

  // Clear select word from a write-one to a status register
  always_comb
  begin
    clear_select_word = '0;
    if (AVS_WRITE_IN && st_reg.rvalid && (AVS_ADDRESS_IN == R_STAT_LO || AVS_ADDRESS_IN == R_STAT_HI))
    begin
      clear_select_word = put_half('0, hi_sel, AVS_WRITEDATA_IN & wmask);
    end
  end

  always_comb
  begin
    st_next = st_reg;
    // Sticky bits hold until cleared; level bits follow source
    st_next.status = (st_reg.sticky & ((st_reg.status & ~clear_select_word) | event_now))
                   | (~st_reg.sticky & event_now);
    st_next.rvalid = acc & ~st_reg.rvalid;
    st_next.rdata  = BAD_ADDR_DATA;
    if (acc)
    begin
      // Reads answer from the request cycle, writes land on the released edge
      if (AVS_READ_IN && !st_reg.rvalid)
      begin
        unique case (AVS_ADDRESS_IN)
          R_STAT_LO, R_STAT_HI:     st_next.rdata = get_half(st_reg.status, hi_sel);
          R_STICKY_LO, R_STICKY_HI: st_next.rdata = get_half(st_reg.sticky, hi_sel);
          R_MASKA_LO, R_MASKA_HI,
          R_MASKAB_LO, R_MASKAB_HI: st_next.rdata = get_half(st_reg.mask_a, hi_sel);
          R_MASKB_LO, R_MASKB_HI:   st_next.rdata = get_half(st_reg.mask_b, hi_sel);
          R_RAW_LO, R_RAW_HI:       st_next.rdata = get_half(raw, hi_sel);
          default:                  st_next.rdata = BAD_ADDR_DATA;
        endcase
      end
      else if (AVS_WRITE_IN && st_reg.rvalid)
      begin
        unique case (AVS_ADDRESS_IN)
          R_STICKY_LO, R_STICKY_HI:
            st_next.sticky = put_half(st_reg.sticky, hi_sel,
                                      (get_half(st_reg.sticky, hi_sel) & ~wmask) | (AVS_WRITEDATA_IN & wmask));
          R_MASKA_LO, R_MASKA_HI:
            st_next.mask_a = put_half(st_reg.mask_a, hi_sel,
                                      (get_half(st_reg.mask_a, hi_sel) & ~wmask) | (AVS_WRITEDATA_IN & wmask));
          R_MASKB_LO, R_MASKB_HI:
            st_next.mask_b = put_half(st_reg.mask_b, hi_sel,
                                      (get_half(st_reg.mask_b, hi_sel) & ~wmask) | (AVS_WRITEDATA_IN & wmask));
          R_MASKAB_LO, R_MASKAB_HI:
          begin
            st_next.mask_a = put_half(st_reg.mask_a, hi_sel,
                                      (get_half(st_reg.mask_a, hi_sel) & ~wmask) | (AVS_WRITEDATA_IN & wmask));
            st_next.mask_b = put_half(st_reg.mask_b, hi_sel,
                                      (get_half(st_reg.mask_b, hi_sel) & ~wmask) | (AVS_WRITEDATA_IN & wmask));
          end
          default: st_next.rdata = BAD_ADDR_DATA;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      st_reg.status <= '0;
      st_reg.sticky <= STICKY_RST;
      st_reg.mask_a <= MASK_RST;
      st_reg.mask_b <= MASK_RST;
      st_reg.rdata  <= '0;
      st_reg.rvalid <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      st_reg <= st_next;
    end
  end

  gp_int_pin u_pin_a
  (
    .status_in (st_reg.status),
    .mask_in   (st_reg.mask_a),
    .irq_out   (pin_a)
  );

  gp_int_pin u_pin_b
  (
    .status_in (st_reg.status),
    .mask_in   (st_reg.mask_b),
    .irq_out   (pin_b)
  );

  assign IRQ_PIN_A_OUT       = pin_a;
  assign IRQ_PIN_B_OUT       = pin_b;
  assign IRQ_OUT             = pin_a | pin_b;
  assign AVS_READDATA_OUT    = st_reg.rdata;
  assign AVS_WAITREQUEST_OUT = acc & ~st_reg.rvalid;
  assign AVS_RESPONSE_OUT    = mapped ? 2'h0 : 2'h3;

  // Assertions
  sequence s_new_req;
    CLK_EN_IN && acc && !st_reg.rvalid;
  endsequence

  sequence s_write_done;
    CLK_EN_IN && AVS_WRITE_IN && st_reg.rvalid;
  endsequence

  sequence s_read_req;
    CLK_EN_IN && AVS_READ_IN && !st_reg.rvalid;
  endsequence

  a_sticky_holds: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && st_reg.sticky[10] && st_reg.status[10] && !clear_select_word[10] |=> st_reg.status[10])
    else $error("Sticky bit dropped without clear");

  a_clear_selected: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && st_reg.sticky[36] && clear_select_word[36] && !raw[36] |=> !st_reg.status[36])
    else $error("Selected sticky bit not cleared");

  a_clear_other: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && st_reg.sticky[10] && st_reg.status[10] && clear_select_word[36] && !clear_select_word[10]
    |=> st_reg.status[10])
    else $error("Unselected bit cleared");

  a_set_wins: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && st_reg.sticky[10] && raw[10] && clear_select_word[10] |=> st_reg.status[10])
    else $error("Event lost on clear");

  a_level_follow: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !st_reg.sticky[32] |=> st_reg.status[32] == $past(raw[32]))
    else $error("Level bit does not follow source");

  a_pin_a_or: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    IRQ_PIN_A_OUT == |(st_reg.status & ~st_reg.mask_a))
    else $error("Pin A not OR of unmasked status");

  a_pin_b_or: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    IRQ_PIN_B_OUT == |(st_reg.status & ~st_reg.mask_b))
    else $error("Pin B not OR of unmasked status");

  a_pin_b_low: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_reg.status & ~st_reg.mask_b) == '0 |-> !IRQ_PIN_B_OUT)
    else $error("Pin B high with nothing unmasked");

  a_pin_a_low: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    (st_reg.status & ~st_reg.mask_a) == '0 |-> !IRQ_PIN_A_OUT)
    else $error("Pin A high with nothing unmasked");

  a_full_mask: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    st_reg.mask_a == '1 |-> !IRQ_PIN_A_OUT)
    else $error("Pin A high with every source blocked");

  a_irq_any: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    IRQ_OUT == (IRQ_PIN_A_OUT | IRQ_PIN_B_OUT))
    else $error("Combined interrupt not OR of pins");

  a_mask_keeps: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_write_done ##0 (AVS_ADDRESS_IN >= R_MASKA_LO && AVS_ADDRESS_IN <= R_MASKAB_HI)
    |=> st_reg.status == $past((st_reg.status & st_reg.sticky) | raw))
    else $error("Mask write altered status");

  a_wait_one: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_new_req |=> !AVS_WAITREQUEST_OUT)
    else $error("Access not answered after one wait cycle");

  a_read_status: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_read_req ##0 (AVS_ADDRESS_IN == R_STAT_LO) |=> AVS_READDATA_OUT == $past(st_reg.status[31:0]))
    else $error("Status read returned wrong data");

  a_read_unmapped: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    s_read_req ##0 !mapped |=> AVS_READDATA_OUT == BAD_ADDR_DATA)
    else $error("Unmapped read returned data");

  a_resp_unmapped: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    acc && !mapped |-> AVS_RESPONSE_OUT == 2'h3)
    else $error("Unmapped access not flagged");

  a_spi_map: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !st_reg.sticky[B_SPI1_ABORT] |=> st_reg.status[B_SPI1_ABORT] == $past(SPI_ABORT_IN[3]))
    else $error("Port abort not at its bit");

  a_core0_map: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !st_reg.sticky[9] |=> st_reg.status[9] == $past(CORE0_EVENT_IN[4]))
    else $error("Core 0 forced event not at bit 9");

  a_core1_map: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && !st_reg.sticky[0] |=> st_reg.status[0] == $past(CORE1_EVENT_IN[0]))
    else $error("Core 1 memory event not at bit 0");

  a_tx_slew_map: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && TX_SLEW_IN[7] |=> st_reg.status[25])
    else $error("Slew event of channel 7 not at bit 25");

  a_tx_pwr_map: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    CLK_EN_IN && TX_POWER_IN[0] |=> st_reg.status[10])
    else $error("Power event of channel 0 not at bit 10");

  a_freeze: assert property (@(posedge CLK_IN) disable iff (SYS_RST_IN)
    !CLK_EN_IN |=> st_reg == $past(st_reg))
    else $error("State changed while clock enable low");
endmodule // gp_interrupt_aggregator
`default_nettype wire

// ==== bench/host_model.sv ====
// Host side model: counts rising edges on both interrupt pins.
// Assumes the pins are synchronous to the device clock.
`default_nettype none
module host_model
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pin_a_in,
  input  wire logic       pin_b_in,
  output logic      [7:0] edges_a_out,
  output logic      [7:0] edges_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_reg;
  logic b_reg;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      a_reg       <= 1'b0;
      b_reg       <= 1'b0;
      edges_a_out <= 8'h00;
      edges_b_out <= 8'h00;
    end
    else
    begin
      a_reg <= pin_a_in;
      b_reg <= pin_b_in;
      edges_a_out <= edges_a_out + 8'((pin_a_in && !a_reg) ? 1 : 0);
      edges_b_out <= edges_b_out + 8'((pin_b_in && !b_reg) ? 1 : 0);
    end
  end
endmodule // host_model
`default_nettype wire

// ==== bench/testbench.sv ====
// Testbench: register tasks over Avalon-MM, source stimulus, pin checks.
// Assumes one wait cycle per access and status lagging sources by a cycle.
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
  import gp_int_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, pa, pb, irq, wreq, en;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, q;
  logic [1:0]  resp, last_resp;
  logic [47:0] src, v;
  logic [7:0]  tx_slew, tx_pow, ea, eb;
  int          err_count, comparisons;
  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      tx_slew[n] = src[11 + 2 * n];
      tx_pow[n]  = src[10 + 2 * n];
    end
  end
  gp_interrupt_aggregator i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(en),
    .SPI_ABORT_IN(src[36:33]), .PLL_EVENT_IN(src[32:26]), .TX_SLEW_IN(tx_slew),
    .TX_POWER_IN(tx_pow), .CORE0_EVENT_IN(src[9:5]), .CORE1_EVENT_IN(src[4:0]),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(4'hF), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
    .AVS_RESPONSE_OUT(resp), .IRQ_PIN_A_OUT(pa), .IRQ_PIN_B_OUT(pb), .IRQ_OUT(irq));
  host_model i_host (.clk_in(clk), .rst_in(rst), .pin_a_in(pa), .pin_b_in(pb),
    .edges_a_out(ea), .edges_b_out(eb));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    if (n >= 20) err_count++;
    r = rdata;
    last_resp = resp;
    rd <= 1'b0; wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd48(input logic [4:0] a, output logic [47:0] r);
    logic [31:0] lo, hi;
    bus(1'b0, a, 32'h0000_0000, lo);
    bus(1'b0, a + 5'h01, 32'h0000_0000, hi);
    r = {hi[15:0], lo};
  endtask
  task automatic wr48(input logic [4:0] a, input logic [47:0] d);
    logic [31:0] t;
    bus(1'b1, a, d[31:0], t);
    bus(1'b1, a + 5'h01, {16'h0000, d[47:32]}, t);
  endtask
  task automatic setsrc(input logic [47:0] d);
    @(posedge clk);
    src <= d;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  initial
  begin
    src = '0; rd = 1'b0; wr = 1'b0; addr = '0; wdata = '0; rst = 1'b1; en = 1'b1;
    err_count = 0; comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd48(5'h04, v); `CHK(v, 48'hFFFF_FFFF_FFFF)
    rd48(5'h06, v); `CHK(v, 48'hFFFF_FFFF_FFFF)
    rd48(5'h02, v); `CHK(v, 48'h0000_0000_0000)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 37; i++)
    begin
      setsrc(48'h1 << i);
      rd48(5'h00, v); `CHK(v, 48'h1 << i)
      `CHK(irq, 1'b0)
    end
    setsrc(48'h0);
    wr48(5'h04, 48'hFFFF_0000_0000);
    setsrc(48'h0000_0000_0400);
    `CHK({pa, pb, irq}, 3'b101)
    setsrc(48'h0);
    `CHK(pa, 1'b0)
    `CHK(ea, 8'h01)
    wr48(5'h02, 48'h0010_0000_0400);
    setsrc(48'h0010_0000_0400);
    setsrc(48'h0);
    rd48(5'h00, v); `CHK(v, 48'h0010_0000_0400)
    `CHK({pa, pb}, 2'b10)
    wr48(5'h06, 48'hFFEF_FFFF_FFFF);
    rd48(5'h00, v); `CHK(v, 48'h0010_0000_0400)
    `CHK({pa, pb}, 2'b11)
    bus(1'b1, 5'h01, 32'h0000_0010, q);
    rd48(5'h00, v); `CHK(v, 48'h0000_0000_0400)
    `CHK({pa, pb}, 2'b10)
    @(posedge clk);
    src <= 48'h0000_0000_0400;
    bus(1'b1, 5'h00, 32'h0000_0400, q);
    rd48(5'h00, v); `CHK(v, 48'h0000_0000_0400)
    setsrc(48'h0);
    bus(1'b1, 5'h00, 32'h0000_0400, q);
    rd48(5'h00, v); `CHK(v, 48'h0000_0000_0000)
    `CHK(irq, 1'b0)
    bus(1'b1, 5'h08, 32'h0000_0000, q);
    rd48(5'h04, v); `CHK(v, 48'hFFFF_0000_0000)
    rd48(5'h06, v); `CHK(v, 48'hFFEF_0000_0000)
    bus(1'b0, 5'h1F, 32'h0000_0000, q);
    `CHK(q, 32'h0000_0000)
    `CHK(last_resp, 2'b11)
    bus(1'b1, 5'h0A, 32'hFFFF_FFFF, q);
    rd48(5'h0A, v); `CHK(v, 48'h0000_0000_0000)
    // Clock enable low freezes the status, release lets the event in
    @(posedge clk);
    en <= 1'b0;
    src <= 48'h0000_0000_0400;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK({pa, pb}, 2'b00)
    @(posedge clk);
    en <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK({pa, pb}, 2'b11)
    `CHK(eb, 8'h02)
    finish_test();
  end
endmodule // testbench
`default_nettype wire
